// ---- pio_port.sv ----
// Parallel I/O port with AXI4-Lite register access and change interrupt.
// Assumes pads resolve pin levels from pin_out and pin_oe outside.
// Operation
// - Direction bit one makes the pin an input and releases its driver.
// - Direction bit zero drives the pin from the output latch.
// - After reset every pin is an input.
// - Analog-shared pins come out of reset in analog mode.
// - Pin-state read returns the pin levels, not the latch.
// - Pin-state write goes into the output latch.
// - Latch takes writes to itself or pin-state, latest wins.
// - Latch read returns the last value written through either register.
// - Unimplemented pins read zero in direction, latch and pin-state.
// - An active alternate function takes over the pin.
// - Each pin has its own open-drain enable.
// - Each pin has its own weak pull-up enable.
// - Selected input pins raise an interrupt when they change.
// - Clear, set and invert aliases touch only bits written as one.
// - Clear, set, invert aliases sit at base plus 4, 8, 12.
// - Alias reads return zero; read the base register.
// - An analog pin reads zero in pin-state; alt_in still follows its pad.
module pio_port (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins.
    input wire logic [15:0] pin_in,
    output logic [15:0] pin_out,
    output logic [15:0] pin_oe,
    output logic [15:0] pull_up_en,
    output logic [15:0] analog_en,
    // Alternate peripheral functions.
    input wire logic [15:0] alt_out,
    input wire logic [15:0] alt_oe,
    output logic [15:0] alt_in,
    // Interrupt.
    output logic irq
);

    // All state of the port sits in one packed struct.
    // The bus side holds each captured write half until the write is done,
    // and the read answer until the master takes it. The pin side holds the
    // configuration words, the last digital pin view for change detection,
    // and the status and enable bits of the change interrupt.
    // Nothing outside this struct holds state; the synchroniser keeps its
    // own two stages.
    typedef struct packed {
        pio_pkg::pio_wr_e wst;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [15:0] dir;
        logic [15:0] lat;
        logic [15:0] odr;
        logic [15:0] pue;
        logic [15:0] cne;
        logic [15:0] dig;
        logic [15:0] alt;
        logic [15:0] prev;
        logic ist;
        logic ien;
    } pio_port_s;

    // Registered state, its next value, and combinational helpers.
    pio_port_s s_q, s_d;
    logic [15:0] pin_sync;
    logic [15:0] pin_view;
    logic [15:0] alias_cur;
    logic [15:0] alias_nxt;
    logic [15:0] wmask;
    logic [15:0] changed;
    logic wr_fire;

    // Byte strobes to a 16-bit write mask.
    // Only the two low strobes matter: every register is at most 16 bits wide
    // and the upper half of the data word is never used.
    function automatic logic [15:0] strb_mask(input logic [3:0] strb);
        strb_mask = {{8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // Base register group of an address, alias bits removed.
    // A group spans sixteen bytes, the base word and its three aliases,
    // so one decode serves all four addresses.
    function automatic logic [7:0] group_of(input logic [7:0] a);
        group_of = {a[7:4], 4'h0};
    endfunction

    // Alias code of an address: base, clear, set or invert.
    // The alias code sits just above the byte offset in the word.
    function automatic logic [1:0] alias_of(input logic [7:0] a);
        alias_of = a[3:2];
    endfunction

    // Pin levels are synchronised before anyone reads them.
    // A raw pad level may go metastable or look different to two readers
    // in one cycle. The pin-state read, the change detector and the
    // alternate functions all use the second stage only, which costs two
    // cycles of delay.
    pio_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // Digital view of pins; analog pins read zero, missing pins zero.
    // An analog pin is masked out of this view: it reads zero and can never
    // trigger the change detector, whatever level its pad shows. Pins that
    // the port lacks are masked here as well.
    assign pin_view = pin_sync & s_q.dig & pio_pkg::PIN_IMPL_MASK;

    // Pick the register the pending write targets.
    // The pin-state group has no storage of its own: its writes and aliases
    // land in the output latch, so the latch is their starting value.
    // Status and clear have no word to modify.
    // Unknown groups give zero and are refused when the write is done.
    always_comb begin
        unique case (group_of(s_q.awaddr))
            pio_pkg::ADDR_DIR: alias_cur = s_q.dir;
            pio_pkg::ADDR_PIN: alias_cur = s_q.lat;
            pio_pkg::ADDR_LAT: alias_cur = s_q.lat;
            pio_pkg::ADDR_ODR: alias_cur = s_q.odr;
            pio_pkg::ADDR_PUE: alias_cur = s_q.pue;
            pio_pkg::ADDR_CNE: alias_cur = s_q.cne;
            pio_pkg::ADDR_DIG: alias_cur = s_q.dig;
            pio_pkg::ADDR_ALT: alias_cur = s_q.alt;
            pio_pkg::ADDR_IEN: alias_cur = {{15{1'b0}}, s_q.ien};
            default: alias_cur = pio_pkg::ZERO16;
        endcase
    end

    // Clear, set and invert arithmetic on the targeted register.
    // Strobes are applied after the alias operation, so a masked byte keeps
    // its old value whatever the alias would have done.
    pio_alias u_alias (
        .alias_sel(alias_of(s_q.awaddr)),
        .cur(alias_cur),
        .wdata(s_q.wdata[15:0]),
        .nxt(alias_nxt)
    );

    // Write mask, write trigger and change detection.
    // A change counts only on a monitored input pin: an output follows its
    // own latch, and reporting it would only echo software's own writes.
    // The previous view is refreshed every cycle, so a change fires once.
    assign wmask = strb_mask(s_q.wstrb);
    assign wr_fire = (s_q.wst == pio_pkg::PIO_WR_IDLE) && s_q.aw_got && s_q.w_got;
    assign changed = (pin_view ^ s_q.prev) & s_q.cne & s_q.dir;

    // Next-state logic: bus handshakes, register writes, change detection.
    // Each write half is captured on its own handshake while no response is
    // pending. With both halves held the write is performed in the next cycle
    // and the response raised at that edge, one edge after the later half.
    // The readies stay low until the response is taken, so one write at a
    // time is in flight.
    // A read may run alongside a write; the two paths share no bus state.
    always_comb begin
        logic [15:0] merged;
        logic [7:0] grp;
        logic hit;
        merged = (alias_nxt & wmask) | (alias_cur & ~wmask);
        grp = group_of(s_q.awaddr);
        hit = 1'b1;
        s_d = s_q;
        // Address and data are accepted in either order.
        // A half that arrives first simply waits for the other; its ready
        // stays low meanwhile.
        if (s_axi_awvalid && !s_q.aw_got && s_q.wst == pio_pkg::PIO_WR_IDLE) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_got && s_q.wst == pio_pkg::PIO_WR_IDLE) begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        // Change detection on monitored input pins.
        // The flag is sticky: any monitored change sets it, and it stays set
        // until software writes the clear word. A change in the cycle of the
        // clear wins, so no event is lost.
        s_d.prev = pin_view;
        if (|changed) begin
            s_d.ist = 1'b1;
        end
        // Perform the write once both halves are in.
        // Unmapped groups change nothing and answer with an error. Status
        // writes are ignored but answered as good: the status bit is read-only
        // and clears only through the clear word.
        if (wr_fire) begin
            unique case (grp)
                pio_pkg::ADDR_DIR: s_d.dir = merged & pio_pkg::PIN_IMPL_MASK;
                pio_pkg::ADDR_PIN: s_d.lat = merged & pio_pkg::PIN_IMPL_MASK;
                pio_pkg::ADDR_LAT: s_d.lat = merged & pio_pkg::PIN_IMPL_MASK;
                pio_pkg::ADDR_ODR: s_d.odr = merged & pio_pkg::PIN_IMPL_MASK;
                pio_pkg::ADDR_PUE: s_d.pue = merged & pio_pkg::PIN_IMPL_MASK;
                pio_pkg::ADDR_CNE: s_d.cne = merged & pio_pkg::PIN_IMPL_MASK;
                pio_pkg::ADDR_DIG: s_d.dig = merged & pio_pkg::PIN_IMPL_MASK;
                pio_pkg::ADDR_ALT: s_d.alt = merged & pio_pkg::PIN_IMPL_MASK;
                pio_pkg::ADDR_IEN: s_d.ien = merged[pio_pkg::IRQ_CHANGE];
                pio_pkg::ADDR_ICL: begin
                    // A new change in the same cycle keeps the flag set.
                    if (s_q.wdata[pio_pkg::IRQ_CHANGE] && !(|changed)) begin
                        s_d.ist = 1'b0;
                    end
                end
                pio_pkg::ADDR_IST: hit = 1'b1;
                default: hit = 1'b0;
            endcase
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bresp = hit ? pio_pkg::RESP_OKAY : pio_pkg::RESP_SLVERR;
            s_d.wst = pio_pkg::PIO_WR_RESP;
        end
        // The response stands until bready is seen; the readies return at
        // that edge, ready for the next write.
        if (s_q.wst == pio_pkg::PIO_WR_RESP && s_axi_bready) begin
            s_d.wst = pio_pkg::PIO_WR_IDLE;
        end
        // Read channel: one cycle from address to data.
        // The answer is registered at the same edge that takes the address and
        // stands until rready is seen. The address ready is the inverse of
        // rvalid, so an untaken answer is never overwritten.
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = pio_pkg::RESP_OKAY;
            s_d.rdata = pio_pkg::ZERO32;
            // Alias reads give zero; only base registers show content.
            // Software reads the base word to see what an alias write did;
            // the clear word has nothing to show and reads zero.
            if (alias_of(s_axi_araddr) == pio_pkg::ALIAS_BASE) begin
                unique case (group_of(s_axi_araddr))
                    pio_pkg::ADDR_DIR: s_d.rdata[15:0] = s_q.dir;
                    pio_pkg::ADDR_PIN: s_d.rdata[15:0] = pin_view;
                    pio_pkg::ADDR_LAT: s_d.rdata[15:0] = s_q.lat;
                    pio_pkg::ADDR_ODR: s_d.rdata[15:0] = s_q.odr;
                    pio_pkg::ADDR_PUE: s_d.rdata[15:0] = s_q.pue;
                    pio_pkg::ADDR_CNE: s_d.rdata[15:0] = s_q.cne;
                    pio_pkg::ADDR_DIG: s_d.rdata[15:0] = s_q.dig;
                    pio_pkg::ADDR_ALT: s_d.rdata[15:0] = s_q.alt;
                    pio_pkg::ADDR_IST: s_d.rdata[pio_pkg::IRQ_CHANGE] = s_q.ist;
                    pio_pkg::ADDR_IEN: s_d.rdata[pio_pkg::IRQ_CHANGE] = s_q.ien;
                    pio_pkg::ADDR_ICL: s_d.rdata = pio_pkg::ZERO32;
                    default: s_d.rresp = pio_pkg::RESP_SLVERR;
                endcase
            end else if (group_of(s_axi_araddr) > pio_pkg::ADDR_IEN) begin
                s_d.rresp = pio_pkg::RESP_SLVERR;
            end
        end
    end

    // State register; all pins inputs and analog pins analog after reset.
    // Reset is synchronous. It clears everything, then makes every pin an
    // input and puts the analog-shared pins back in analog mode, so no
    // driver fights an external source and neither the pin-state read nor the
    // change detector sees an analog level before software sets the port up.
    // The status flag and its enable come up clear, so irq starts low.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.wst <= pio_pkg::PIO_WR_IDLE;
            s_q.dir <= pio_pkg::DIR_RESET & pio_pkg::PIN_IMPL_MASK;
            s_q.dig <= ~pio_pkg::PIN_ANALOG_MASK & pio_pkg::PIN_IMPL_MASK;
        end else begin
            s_q <= s_d;
        end
    end

    // Pad drive: alternate function first, then port output or open-drain.
    // An active alternate function owns the level and the enable of its pin.
    // Otherwise an input releases the pad, a push-pull output drives the
    // latch, and an open-drain output only pulls low: a latch one releases
    // the pad and leaves the level to an external pull-up.
    always_comb begin
        for (int i = 0; i < pio_pkg::PIN_W; i++) begin
            if (s_q.alt[i]) begin
                pin_out[i] = alt_out[i];
                pin_oe[i] = alt_oe[i];
            end else if (s_q.dir[i]) begin
                pin_out[i] = 1'b0;
                pin_oe[i] = 1'b0;
            end else if (s_q.odr[i]) begin
                pin_out[i] = 1'b0;
                pin_oe[i] = ~s_q.lat[i];
            end else begin
                pin_out[i] = s_q.lat[i];
                pin_oe[i] = 1'b1;
            end
        end
    end

    // Side outputs.
    // The pull-up acts on direction-input pins only, so a port-driven output never has it on.
    // The interrupt is a level that stands while the status bit and its
    // enable are both set; clearing either lowers it at the edge that
    // performs the write.
    assign pull_up_en = s_q.pue & s_q.dir;
    assign analog_en = ~s_q.dig & pio_pkg::PIN_IMPL_MASK;
    assign alt_in = pin_sync;
    assign irq = s_q.ist & s_q.ien;

    // AXI outputs.
    // The readies depend on the state register only, never on the master's
    // valids, so no combinational loop can form across the bus.
    // The write response and the read answer are registered outputs.
    assign s_axi_awready = !s_q.aw_got && s_q.wst == pio_pkg::PIO_WR_IDLE;
    assign s_axi_wready = !s_q.w_got && s_q.wst == pio_pkg::PIO_WR_IDLE;
    assign s_axi_bvalid = s_q.wst == pio_pkg::PIO_WR_RESP;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;

endmodule // pio_port

// ---- pio_pkg.sv ----
// Package for the parallel I/O port: register map, widths, reset values.
// Assumes a 32-bit AXI4-Lite register bus and a single peripheral clock.
package pio_pkg;

    // Port width and the mask of pins that exist on this part.
    localparam int unsigned PIN_W = 16;
    localparam logic [15:0] PIN_IMPL_MASK = 16'hffff;
    // Pins that share an analog function.
    localparam logic [15:0] PIN_ANALOG_MASK = 16'h00ff;

    // Register byte addresses (base registers).
    localparam logic [7:0] ADDR_DIR = 8'h00;
    localparam logic [7:0] ADDR_PIN = 8'h10;
    localparam logic [7:0] ADDR_LAT = 8'h20;
    localparam logic [7:0] ADDR_ODR = 8'h30;
    localparam logic [7:0] ADDR_PUE = 8'h40;
    localparam logic [7:0] ADDR_CNE = 8'h50;
    localparam logic [7:0] ADDR_DIG = 8'h60;
    localparam logic [7:0] ADDR_ALT = 8'h70;
    localparam logic [7:0] ADDR_IST = 8'h80;
    localparam logic [7:0] ADDR_ICL = 8'h90;
    localparam logic [7:0] ADDR_IEN = 8'ha0;

    // Alias offsets within a register group.
    localparam logic [1:0] ALIAS_BASE = 2'h0;
    localparam logic [1:0] ALIAS_CLR = 2'h1;
    localparam logic [1:0] ALIAS_SET = 2'h2;
    localparam logic [1:0] ALIAS_INV = 2'h3;

    // Reset values.
    localparam logic [15:0] DIR_RESET = 16'hffff;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;

    // Interrupt status bits.
    localparam int unsigned IRQ_W = 1;
    localparam int unsigned IRQ_CHANGE = 0;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Write state machine.
    typedef enum logic [1:0] {
        PIO_WR_IDLE,
        PIO_WR_RESP
    } pio_wr_e;

endpackage

// ---- pio_sync.sv ----
// Two-flop synchroniser for a bank of pin levels.
// Assumes the inputs are asynchronous to aclk.
module pio_sync (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Levels.
    input wire logic [15:0] async_in,
    output logic [15:0] sync_out
);

    typedef struct packed {
        logic [15:0] meta;
        logic [15:0] sync;
    } pio_sync_s;

    pio_sync_s s_q, s_d;

    // The first stage is read by the second stage only.
    always_comb begin
        s_d = s_q;
        s_d.meta = async_in;
        s_d.sync = s_q.meta;
    end

    // State register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.sync;

endmodule // pio_sync

// ---- pio_alias.sv ----
// Applies a base, clear, set or invert alias write to a register value.
// Assumes the alias code is one of the four package alias offsets.
module pio_alias (
    // Operation.
    input wire logic [1:0] alias_sel,
    input wire logic [15:0] cur,
    input wire logic [15:0] wdata,
    // Result.
    output logic [15:0] nxt
);

    // Only bits written as one are touched by the clear, set and invert aliases.
    always_comb begin
        unique case (alias_sel)
            pio_pkg::ALIAS_CLR: nxt = cur & ~wdata;
            pio_pkg::ALIAS_SET: nxt = cur | wdata;
            pio_pkg::ALIAS_INV: nxt = cur ^ wdata;
            default: nxt = wdata;
        endcase
    end

endmodule // pio_alias

// ---- pio_props.sv ----
// Port-level assertions for the parallel I/O port.
// Assumes it is bound to pio_port and sees only that module's ports.
module pio_props (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus.
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins.
    input wire logic [15:0] pin_in,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] pull_up_en,
    input wire logic [15:0] analog_en,
    input wire logic [15:0] alt_oe,
    input wire logic [15:0] alt_in,
    // Interrupt.
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // All checks run on the bus clock and pause during reset.
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Pin checks.
    reset_state_a: assert property (
        $rose(aresetn) |-> pin_oe == 16'h0000 && analog_en == 16'h00ff)
        else $error("pins not inputs after reset");
    sync_delay_a: assert property (
        $past(aresetn) && $past(aresetn, 2)
        |-> (alt_in & ~analog_en) == ($past(pin_in, 2) & ~analog_en))
        else $error("pin levels not delayed by two edges");
    pullup_input_a: assert property (
        (pull_up_en & pin_oe & ~alt_oe) == 16'h0000)
        else $error("pull-up on a driven pin");
    // Interrupt only moves on a pin change or a register write.
    irq_rise_a: assert property (
        $rose(irq) |-> $rose(s_axi_bvalid) || $past(alt_in) != $past(alt_in, 2))
        else $error("interrupt rose without cause");
    irq_fall_a: assert property (
        $fell(irq) |-> $rose(s_axi_bvalid))
        else $error("interrupt fell without a write");
    // Bus answers.
    write_answer_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write response late");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    // Main scenarios.
    irq_up_c: cover property ($rose(irq));
    irq_down_c: cover property ($fell(irq));
    wr_done_c: cover property (s_axi_bvalid && s_axi_bready);
endmodule // pio_props

// ---- pio_pins.sv ----
// Far-side devices on the port pins: resolves each pad level.
// Assumes one clock; a released pad without pull-up flips every cycle.
module pio_pins (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Port side.
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] pull_up_en,
    // Far drivers.
    input wire logic [15:0] ext_val,
    input wire logic [15:0] ext_en,
    output logic [15:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] last_q;
    // Port drive wins, then a far driver, then the pull-up.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pull_up_en | ~last_q));
    // A floating pad shows the inverse of its last level; reset gives it a known start.
    always_ff @(posedge aclk) last_q <= aresetn ? pin_in : 16'h0000;
endmodule // pio_pins

// ---- parallel_io_port_tb.sv ----
// Self-checking bench for the parallel I/O port.
// Assumes pio_port, pio_pins and pio_props are compiled before it.
module parallel_io_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [1:0] r;} pio_row_s;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] pin_in, pin_out, pin_oe, pull_up_en, analog_en, alt_in;
    logic [15:0] alt_out = 16'h0, alt_oe = 16'h0, ext_val = 16'h0, ext_en = 16'h0;
    int errors = 0, n_compared = 0, cycles = 0;
    pio_row_s rows [15] = '{'{1, 8'h20, 32'h1234, 2'h0}, '{0, 8'h20, 32'h1234, 2'h0},
        '{1, 8'h10, 32'h00a5, 2'h0}, '{0, 8'h20, 32'h00a5, 2'h0},
        '{1, 8'h24, 32'h0005, 2'h0}, '{0, 8'h20, 32'h00a0, 2'h0},
        '{1, 8'h28, 32'h0f00, 2'h0}, '{0, 8'h20, 32'h0fa0, 2'h0},
        '{1, 8'h2c, 32'h00ff, 2'h0}, '{0, 8'h20, 32'h0f5f, 2'h0},
        '{0, 8'h24, 32'h0000, 2'h0}, '{0, 8'h00, 32'hffff, 2'h0},
        '{0, 8'h60, 32'hff00, 2'h0}, '{0, 8'hc0, 32'h0000, 2'h2},
        '{1, 8'hc0, 32'h0001, 2'h2}};
    pio_port pio_port_i (.*);
    pio_pins pio_pins_i (.*);
    always #12.5 aclk = ~aclk;
    // Cuts a hang short.
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            $display("[ERR] %0t timeout", $time);
            errors = errors + 1;
            report_and_stop();
        end
    end
    // Compares a seen value with the expected one.
    task check(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Bus write; each half is released at the edge that takes it.
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        logic aw_t, w_t, b_t;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b_t = 1'b0;
        while (!b_t) begin
            @(negedge aclk);
            aw_t = s_axi_awvalid & s_axi_awready;
            w_t = s_axi_wvalid & s_axi_wready;
            b_t = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        check({30'h0, r}, {30'h0, e});
    endtask
    // Bus read with expected data and response.
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic a_t, r_t;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r_t = 1'b0;
        while (!r_t) begin
            @(negedge aclk);
            a_t = s_axi_arvalid & s_axi_arready;
            r_t = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (a_t) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        check(d, e);
        check({30'h0, r}, {30'h0, er});
    endtask
    // Prints the counts and the verdict, then ends the run.
    task report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        check({pin_oe, analog_en}, 32'h0000_00ff);
        check({31'h0, irq}, 32'h0);
        $display("reset test done");
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d, rows[i].r);
            else rd(rows[i].a, rows[i].d, rows[i].r);
        end
        $display("table test done");
        wr(8'h00, 32'hff00, 2'h0);
        wr(8'h60, 32'hffff, 2'h0);
        ext_en <= 16'hff00;
        ext_val <= 16'ha500;
        check({pin_oe, pin_out & 16'h00ff}, 32'h00ff_005f);
        repeat (3) @(posedge aclk);
        rd(8'h10, 32'ha55f, 2'h0);
        wr(8'h64, 32'h0001, 2'h0);
        check({16'h0, analog_en}, 32'h0001);
        rd(8'h10, 32'ha55e, 2'h0);
        wr(8'h30, 32'h0001, 2'h0);
        check({pin_oe, pin_out & 16'h0001}, 32'h00fe_0000);
        wr(8'h40, 32'hffff, 2'h0);
        check({16'h0, pull_up_en}, 32'hff00);
        ext_en <= 16'h0000;
        repeat (3) @(posedge aclk);
        rd(8'h10, 32'hff5e, 2'h0);
        $display("pin tests done");
        wr(8'h50, 32'h0200, 2'h0);
        wr(8'ha0, 32'h0001, 2'h0);
        ext_en <= 16'h0200;
        repeat (5) @(posedge aclk);
        check({31'h0, irq}, 32'h1);
        rd(8'h80, 32'h1, 2'h0);
        wr(8'h90, 32'h1, 2'h0);
        check({31'h0, irq}, 32'h0);
        wr(8'ha0, 32'h0, 2'h0);
        ext_en <= 16'h0000;
        repeat (5) @(posedge aclk);
        check({31'h0, irq}, 32'h0);
        rd(8'h80, 32'h1, 2'h0);
        $display("irq test done");
        alt_oe <= 16'h0100;
        alt_out <= 16'h0100;
        wr(8'h70, 32'h0100, 2'h0);
        check({pin_oe & 16'h0100, pin_out & 16'h0100}, 32'h0100_0100);
        wr(8'h08, 32'h00ff, 2'h0);
        check({16'h0, pin_oe & 16'h00ff}, 32'h0);
        s_axi_wstrb <= 4'h1;
        wr(8'h20, 32'hffff, 2'h0);
        s_axi_wstrb <= 4'hf;
        rd(8'h20, 32'h0fff, 2'h0);
        $display("alternate and direction tests done");
        report_and_stop();
    end
endmodule // parallel_io_port_tb
bind pio_port pio_props pio_props_i (.*);
